// ==== msbt_map.svh ====
// register indices, field positions, reset values and timing counts
`ifndef MSBT_MAP_SVH
`define MSBT_MAP_SVH
// register indices; byte address is four times the index
`define MSBT_IDX_CFG 10'h080
`define MSBT_IDX_DPTR0 10'h081
`define MSBT_IDX_DPTR1 10'h082
`define MSBT_IDX_XCMD 10'h083
`define MSBT_IDX_XDATA 10'h084
`define MSBT_IDX_STAT 10'h085
`define MSBT_IDX_SUM 10'h086
`define MSBT_IDX_SUMCTL 10'h087
`define MSBT_IDX_GPIO 10'h088
`define MSBT_IDX_TMR 10'h089
`define MSBT_IDX_CKCTL 10'h08e
// reset values
`define MSBT_CKCTL_RST 8'h01
`define MSBT_CFG_RST 8'h00
// field positions
`define MSBT_CK_FAST 3
`define MSBT_CFG_BUS 0
`define MSBT_CFG_DPS 1
`define MSBT_CFG_IDLE 2
`define MSBT_XCMD_WR 0
`define MSBT_XCMD_AUTO 1
`define MSBT_SUM_CLR 5
// timing counts: last value of each up-counter, load value of the address latch down-counter
`define MSBT_INSTR_LAST 2'h3
`define MSBT_SLOW_LAST 4'hb
`define MSBT_ALE_LAST 5'h03
`endif

// ==== msbt_pkg.sv ====
// types and timing decode shared by the bus timing block
package msbt_pkg;
  typedef enum logic [1:0] {
    MSBT_IDLE = 2'b00,
    MSBT_ADDR = 2'b01,
    MSBT_STRB = 2'b10,
    MSBT_HOLD = 2'b11
  } msbt_state_t;

  // strobe width in system clocks for a stretch code
  function automatic logic [4:0] msbt_strobe_clks(input logic [2:0] sel);
    msbt_strobe_clks = (sel == 3'h0) ? 5'h02 : {sel, 2'b00};
  endfunction

  // clocks after the strobe to fill out whole instruction cycles
  function automatic logic [4:0] msbt_hold_clks(input logic [2:0] sel);
    msbt_hold_clks = (sel == 3'h0) ? 5'h02 : 5'h04;
  endfunction
endpackage

// ==== msbt_timing.sv ====
// instruction cycle and timer tick generator
`timescale 1ns/1ps
`include "msbt_map.svh"

module msbt_timing (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic fast,
  output logic instr_tick,
  output logic timer_tick
);
  logic [1:0] ph_q;
  logic [3:0] slow_q;
  logic [3:0] gap_q;

  // sys_clk is the oscillator itself, no prescaler [RULE2]
  always_ff @(posedge sys_clk) begin
    if (!resetn || ph_q == `MSBT_INSTR_LAST) begin
      ph_q <= 2'h0; // four clocks per instruction cycle [RULE1]
    end else begin
      ph_q <= ph_q + 2'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn || slow_q == `MSBT_SLOW_LAST) begin
      slow_q <= 4'h0;
    end else begin
      slow_q <= slow_q + 4'h1;
    end
  end

  assign instr_tick = (ph_q == `MSBT_INSTR_LAST);
  // twelve clocks by default, four when fast [RULE3]
  assign timer_tick = fast ? instr_tick : (slow_q == `MSBT_SLOW_LAST);

  always_ff @(posedge sys_clk) begin
    if (!resetn || timer_tick) begin
      gap_q <= 4'h0;
    end else begin
      gap_q <= gap_q + 4'h1;
    end
  end

  a_instr_period: assert property (@(posedge sys_clk) disable iff (!resetn)
    instr_tick |=> !instr_tick [*3] ##1 instr_tick) // [RULE1]
    else $error("instruction cycle not four clocks");
  a_timer_slow: assert property (@(posedge sys_clk) disable iff (!resetn)
    (timer_tick && !fast && $past(!fast, 12) && $past(resetn, 12))
      |-> gap_q == 4'hb) // [RULE3]
    else $error("slow timer tick not every twelve clocks");
  a_timer_fast: assert property (@(posedge sys_clk) disable iff (!resetn)
    fast |-> (timer_tick == instr_tick)) // [RULE3]
    else $error("fast timer tick not every four clocks");
endmodule

// ==== msbt_xbus.sv ====
// external data move engine: address latch phase, stretched strobe
`timescale 1ns/1ps
`include "msbt_map.svh"

module msbt_xbus (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic wr,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [2:0] sel,
  input wire logic [7:0] p0_in,
  output logic busy,
  output logic done,
  output logic [7:0] rdata_q,
  output logic ale,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] p0_out,
  output logic p0_oe,
  output logic [7:0] p2_out
);
  msbt_pkg::msbt_state_t st_q;
  logic [4:0] cnt_q;
  logic [2:0] sel_q;
  logic wr_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  logic [5:0] len_q;
  logic [4:0] sw_q;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_q <= msbt_pkg::MSBT_IDLE;
      cnt_q <= 5'h00;
    end else begin
      unique case (st_q)
        msbt_pkg::MSBT_IDLE: if (start) begin
          st_q <= msbt_pkg::MSBT_ADDR;
          cnt_q <= `MSBT_ALE_LAST;
        end
        msbt_pkg::MSBT_ADDR: if (cnt_q == 5'h00) begin
          st_q <= msbt_pkg::MSBT_STRB; // width from stretch code [RULE5]
          cnt_q <= msbt_pkg::msbt_strobe_clks(sel_q) - 5'h01;
        end else begin
          cnt_q <= cnt_q - 5'h01;
        end
        msbt_pkg::MSBT_STRB: if (cnt_q == 5'h00) begin
          st_q <= msbt_pkg::MSBT_HOLD; // total is code plus two cycles [RULE4]
          cnt_q <= msbt_pkg::msbt_hold_clks(sel_q) - 5'h01;
        end else begin
          cnt_q <= cnt_q - 5'h01;
        end
        msbt_pkg::MSBT_HOLD: if (cnt_q == 5'h00) begin
          st_q <= msbt_pkg::MSBT_IDLE;
        end else begin
          cnt_q <= cnt_q - 5'h01;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sel_q <= 3'h1;
      wr_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
    end else if (start && st_q == msbt_pkg::MSBT_IDLE) begin
      sel_q <= sel;
      wr_q <= wr;
      addr_q <= addr;
      wdata_q <= wdata;
    end
  end

  // peripheral must have data valid by the strobe's last clock [RULE12]
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (st_q == msbt_pkg::MSBT_STRB && cnt_q == 5'h00 && !wr_q) begin
      rdata_q <= p0_in;
    end
  end

  assign busy = (st_q != msbt_pkg::MSBT_IDLE);
  assign done = (st_q == msbt_pkg::MSBT_HOLD) && (cnt_q == 5'h00);
  assign ale = (st_q == msbt_pkg::MSBT_ADDR);
  assign rd_n = !((st_q == msbt_pkg::MSBT_STRB) && !wr_q);
  assign wr_n = !((st_q == msbt_pkg::MSBT_STRB) && wr_q);
  // low address byte then data share port zero [RULE6]
  assign p0_out = ale ? addr_q[7:0] : wdata_q;
  assign p0_oe = ale || (wr_q && busy);
  assign p2_out = addr_q[15:8]; // [RULE6]

  // helper counters for the checks below
  always_ff @(posedge sys_clk) begin
    len_q <= (!resetn || !busy) ? 6'h00 : len_q + 6'h01;
    sw_q <= (!resetn || (rd_n && wr_n)) ? 5'h00 : sw_q + 5'h01;
  end

  a_strobe_width: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(rd_n & wr_n) |-> ({1'b0, $past(sw_q)} + 6'h01
      == {1'b0, msbt_pkg::msbt_strobe_clks(sel_q)})) // [RULE5]
    else $error("strobe width differs from stretch code");
  a_external_data_move_len: assert property (@(posedge sys_clk) disable iff (!resetn)
    done |-> len_q + 6'h01 == {1'b0, sel_q, 2'b00} + 6'h08) // [RULE4]
    else $error("data move length not code plus two cycles");
endmodule

// ==== msbt_top.sv ====
// bus timing block top: apb registers, data pointers, summation, ports
`timescale 1ns/1ps
`include "msbt_map.svh"

// Summary of operation
// RULE1 - an instruction cycle lasts four system clocks, not twelve
// RULE2 - system clock runs at oscillator rate with no divider
// RULE3 - timer ticks every twelve clocks, or every four when fast
// RULE4 - external data move takes stretch code plus two instruction cycles
// RULE5 - strobe is two clocks at code zero, else four times code
// RULE6 - sixteen-bit address: high byte port two, low byte muxed port zero
// RULE7 - a control bit picks memory interface or general purpose ports
// RULE8 - two selectable data pointers speed block moves
// RULE9 - results are unchanged by stretching; only cycle timing differs
// RULE10 - summation register adds and shifts 32 bits in hardware
// RULE11 - peripherals power down individually; core can be put idle
// RULE12 - memory gives read data or takes write data within strobe
module msbt_top (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] p0_in,
  output logic [7:0] p0_out,
  output logic [7:0] p0_oe,
  input wire logic [7:0] p2_in,
  output logic [7:0] p2_out,
  output logic [7:0] p2_oe,
  output logic ale,
  output logic rd_n,
  output logic wr_n,
  output logic instr_en,
  output logic timer_tick,
  output logic core_idle,
  output logic [3:0] periph_pd
);
  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic [7:0] ckctl_q;
  logic [7:0] cfg_q;
  logic [15:0] dptr0_q;
  logic [15:0] dptr1_q;
  logic [7:0] xdata_q;
  logic [31:0] sum_q;
  logic [31:0] gpio_q;
  logic [15:0] tmr_q;
  logic auto_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_d;
  logic [9:0] idx;
  logic acc_w;
  logic hit;
  logic bus_en;
  logic dps;
  logic start;
  logic [15:0] xaddr;
  logic instr_tick;
  logic eng_busy;
  logic eng_done;
  logic [7:0] eng_rdata;
  logic eng_ale;
  logic eng_rd_n;
  logic eng_wr_n;
  logic [7:0] eng_p0;
  logic eng_p0_oe;
  logic [7:0] eng_p2;

  // ------------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------------
  function automatic logic is_mapped(input logic [9:0] i);
    is_mapped = (i == `MSBT_IDX_CKCTL) || (i == `MSBT_IDX_CFG)
             || (i == `MSBT_IDX_DPTR0) || (i == `MSBT_IDX_DPTR1)
             || (i == `MSBT_IDX_XCMD) || (i == `MSBT_IDX_XDATA)
             || (i == `MSBT_IDX_STAT) || (i == `MSBT_IDX_SUM)
             || (i == `MSBT_IDX_SUMCTL) || (i == `MSBT_IDX_GPIO)
             || (i == `MSBT_IDX_TMR);
  endfunction

  function automatic logic wr_to(input logic a, input logic [9:0] i,
                                 input logic [9:0] r);
    wr_to = a && (i == r);
  endfunction

  assign idx = paddr[11:2];
  assign hit = is_mapped(idx);
  assign acc_w = psel && penable && pwrite && hit;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_q;

  assign bus_en = cfg_q[`MSBT_CFG_BUS];
  assign dps = cfg_q[`MSBT_CFG_DPS];
  assign core_idle = cfg_q[`MSBT_CFG_IDLE];
  assign periph_pd = cfg_q[7:4]; // per-peripheral power down [RULE11]

  // ------------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ckctl_q <= `MSBT_CKCTL_RST; // three-cycle stretch at reset [RULE4]
    end else if (wr_to(acc_w, idx, `MSBT_IDX_CKCTL)) begin
      ckctl_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cfg_q <= `MSBT_CFG_RST;
    end else if (wr_to(acc_w, idx, `MSBT_IDX_CFG)) begin
      cfg_q <= pwdata[7:0]; // port mode, pointer select, idle [RULE7]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      xdata_q <= 8'h00;
    end else if (wr_to(acc_w, idx, `MSBT_IDX_XDATA)) begin
      xdata_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      gpio_q <= 32'h0000_0000;
    end else if (wr_to(acc_w, idx, `MSBT_IDX_GPIO)) begin
      gpio_q <= pwdata;
    end
  end

  // ------------------------------------------------------------------
  // dual data pointers
  // ------------------------------------------------------------------
  // software write wins over the post-move increment
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      dptr0_q <= 16'h0000;
    end else if (wr_to(acc_w, idx, `MSBT_IDX_DPTR0)) begin
      dptr0_q <= pwdata[15:0];
    end else if (eng_done && auto_q && !dps) begin
      dptr0_q <= dptr0_q + 16'h0001; // [RULE8]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      dptr1_q <= 16'h0000;
    end else if (wr_to(acc_w, idx, `MSBT_IDX_DPTR1)) begin
      dptr1_q <= pwdata[15:0];
    end else if (eng_done && auto_q && dps) begin
      dptr1_q <= dptr1_q + 16'h0001; // [RULE8]
    end
  end

  assign xaddr = dps ? dptr1_q : dptr0_q; // [RULE8]

  // ------------------------------------------------------------------
  // external data move launch
  // ------------------------------------------------------------------
  // ignored while a move runs or ports are in general purpose mode
  assign start = wr_to(acc_w, idx, `MSBT_IDX_XCMD) && !eng_busy && bus_en;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      auto_q <= 1'b0;
    end else if (start) begin
      auto_q <= pwdata[`MSBT_XCMD_AUTO];
    end
  end

  // ------------------------------------------------------------------
  // summation register
  // ------------------------------------------------------------------
  // one-clock add or shift, well inside an instruction cycle
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sum_q <= 32'h0000_0000;
    end else if (wr_to(acc_w, idx, `MSBT_IDX_SUM)) begin
      sum_q <= sum_q + pwdata; // [RULE10]
    end else if (wr_to(acc_w, idx, `MSBT_IDX_SUMCTL)) begin
      if (pwdata[`MSBT_SUM_CLR]) begin
        sum_q <= 32'h0000_0000;
      end else begin
        sum_q <= sum_q >> pwdata[4:0]; // [RULE10]
      end
    end
  end

  // ------------------------------------------------------------------
  // timer counter
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tmr_q <= 16'h0000;
    end else if (wr_to(acc_w, idx, `MSBT_IDX_TMR)) begin
      tmr_q <= pwdata[15:0];
    end else if (timer_tick) begin
      tmr_q <= tmr_q + 16'h0001; // [RULE3]
    end
  end

  // ------------------------------------------------------------------
  // read path, captured in the setup cycle
  // ------------------------------------------------------------------
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (idx)
      `MSBT_IDX_CKCTL: rd_d = {24'h00_0000, ckctl_q};
      `MSBT_IDX_CFG: rd_d = {24'h00_0000, cfg_q};
      `MSBT_IDX_DPTR0: rd_d = {16'h0000, dptr0_q};
      `MSBT_IDX_DPTR1: rd_d = {16'h0000, dptr1_q};
      `MSBT_IDX_XDATA: rd_d = {24'h00_0000, xdata_q};
      // bytes are passed untouched whatever the stretch [RULE9]
      `MSBT_IDX_STAT: rd_d = {16'h0000, eng_rdata, 7'h00, eng_busy};
      `MSBT_IDX_SUM: rd_d = sum_q;
      `MSBT_IDX_GPIO: rd_d = gpio_q;
      `MSBT_IDX_TMR: rd_d = {p2_in, p0_in, tmr_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rd_d;
    end
  end

  // ------------------------------------------------------------------
  // timing chain and move engine
  // ------------------------------------------------------------------
  msbt_timing u_timing (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .fast(ckctl_q[`MSBT_CK_FAST]),
    .instr_tick(instr_tick),
    .timer_tick(timer_tick)
  );

  // idle halts the core's cycle enable; timers keep running [RULE11]
  assign instr_en = instr_tick && !core_idle;

  msbt_xbus u_xbus (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .start(start),
    .wr(pwdata[`MSBT_XCMD_WR]),
    .addr(xaddr),
    .wdata(xdata_q),
    .sel(ckctl_q[2:0]),
    .p0_in(p0_in),
    .busy(eng_busy),
    .done(eng_done),
    .rdata_q(eng_rdata),
    .ale(eng_ale),
    .rd_n(eng_rd_n),
    .wr_n(eng_wr_n),
    .p0_out(eng_p0),
    .p0_oe(eng_p0_oe),
    .p2_out(eng_p2)
  );

  // ------------------------------------------------------------------
  // port mode select
  // ------------------------------------------------------------------
  // memory interface or general purpose outputs [RULE7]
  assign p0_out = bus_en ? eng_p0 : gpio_q[7:0];
  assign p0_oe = bus_en ? {8{eng_p0_oe}} : gpio_q[15:8];
  assign p2_out = bus_en ? eng_p2 : gpio_q[23:16]; // [RULE6]
  assign p2_oe = bus_en ? 8'hff : gpio_q[31:24];
  assign ale = bus_en && eng_ale;
  assign rd_n = !bus_en || eng_rd_n;
  assign wr_n = !bus_en || eng_wr_n;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_ckctl_reset: assert property (@(posedge sys_clk)
    !resetn |=> ckctl_q == `MSBT_CKCTL_RST) // [RULE4]
    else $error("stretch code not three cycles after reset");
  a_sum_add: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_to(acc_w, idx, `MSBT_IDX_SUM)
      |=> sum_q == $past(sum_q) + $past(pwdata)) // [RULE10]
    else $error("summation add wrong");
  a_p2_addr: assert property (@(posedge sys_clk) disable iff (!resetn)
    start ##1 bus_en |-> p2_out == $past(xaddr[15:8])) // [RULE6]
    else $error("high address byte not on port two");
  a_gpio_mode: assert property (@(posedge sys_clk) disable iff (!resetn)
    !bus_en |-> p0_out == gpio_q[7:0] && p0_oe == gpio_q[15:8]
      && rd_n && wr_n && !ale) // [RULE7]
    else $error("ports not general purpose with bus off");
  a_dptr_auto: assert property (@(posedge sys_clk) disable iff (!resetn)
    (eng_done && auto_q && !dps && !acc_w)
      |=> dptr0_q == $past(dptr0_q) + 16'h0001) // [RULE8]
    else $error("data pointer not advanced after move");
  a_idle_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
    core_idle |-> !instr_en) // [RULE11]
    else $error("core cycle enable while idle");
  a_read_byte: assert property (@(posedge sys_clk) disable iff (!resetn)
    (bus_en && !rd_n ##1 rd_n) |-> eng_rdata == $past(p0_in)) // [RULE9]
    else $error("read byte not the one on the bus");
endmodule

// ==== msbt_xbus_note_unused.sv ====
// (intentionally empty module file not needed)

// ==== msbt_xmem.sv ====
// external data memory model on the far side of the move interface
`timescale 1ns/1ps

module msbt_xmem (
  input wire logic sys_clk,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] p0_bus,
  input wire logic [7:0] p2_bus,
  input wire logic [3:0] lag,
  output logic [7:0] drv,
  output logic [15:0] last_addr
);
  logic [7:0] mem [0:255];
  logic [7:0] junk = 8'h00;
  logic [4:0] rd_age = 5'h00;
  initial last_addr = 16'h0000;
  // released bus shows a changing pattern; data only after lag clocks
  assign drv = (!rd_n && rd_age >= {1'b0, lag}) ? mem[last_addr[7:0]] :
               junk;
  always @(posedge sys_clk) begin
    junk <= ~drv;
    rd_age <= rd_n ? 5'h00 : rd_age + 5'h01;
    if (ale) begin
      last_addr <= {p2_bus, p0_bus};
    end
    if (!wr_n) begin
      mem[last_addr[7:0]] <= p0_bus;
    end
  end
endmodule

// ==== tb_external_data_move_stretch_bus_timing.sv ====
// self-checking bench for the bus timing block
`timescale 1ns/1ps
`include "msbt_map.svh"

module tb_external_data_move_stretch_bus_timing;
  typedef struct {
    logic [2:0] sel;
    logic [15:0] addr;
    logic [7:0] dat;
    int w;
    int tot;
  } msbt_row_t;
  msbt_row_t rows [8] = '{
    '{3'h0, 16'h1200, 8'h3c, 2, 8}, '{3'h1, 16'h2311, 8'ha5, 4, 12},
    '{3'h2, 16'h3422, 8'h5a, 8, 16}, '{3'h3, 16'h4533, 8'h0f, 12, 20},
    '{3'h4, 16'h5644, 8'hf0, 16, 24}, '{3'h5, 16'h6755, 8'h81, 20, 28},
    '{3'h6, 16'h7866, 8'h7e, 24, 32}, '{3'h7, 16'h8977, 8'hc3, 28, 36}};
  msbt_row_t r;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q;
  logic pready, pslverr, se, ale, rd_n, wr_n, instr_en, timer_tick;
  logic core_idle;
  logic [3:0] periph_pd;
  logic [3:0] lag = 4'h0;
  logic [7:0] p0_in, p0_out, p0_oe, p2_out, p2_oe, mem_drv;
  logic [7:0] p2_in = 8'h5a;
  logic [15:0] xaddr;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  int t0, e;
  int cnt [5] = '{0, 0, 0, 0, 0};
  int base [5];

  always #12.5 sys_clk = ~sys_clk;
  assign p0_in = (p0_out & p0_oe) | (mem_drv & ~p0_oe);

  msbt_top DUT (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .p0_in(p0_in),
    .p0_out(p0_out), .p0_oe(p0_oe), .p2_in(p2_in), .p2_out(p2_out),
    .p2_oe(p2_oe), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
    .instr_en(instr_en), .timer_tick(timer_tick), .core_idle(core_idle),
    .periph_pd(periph_pd));
  msbt_xmem xmem (.sys_clk(sys_clk), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
    .p0_bus(p0_in), .p2_bus(p2_out), .lag(lag), .drv(mem_drv),
    .last_addr(xaddr));

  // ----------------------------------------
  // monitors, timeout and checking tasks
  // ----------------------------------------
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    cnt[0] <= cnt[0] + int'(ale === 1'b1);
    cnt[1] <= cnt[1] + int'(rd_n === 1'b0);
    cnt[2] <= cnt[2] + int'(wr_n === 1'b0);
    cnt[3] <= cnt[3] + int'(instr_en === 1'b1);
    cnt[4] <= cnt[4] + int'(timer_tick === 1'b1);
    if (cyc == 6000) begin
      err_total = err_total + 1;
      final_report();
    end
  end

  function automatic logic [31:0] d(input int i);
    d = 32'(cnt[i] - base[i]);
  endfunction

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task apb(input logic w, input logic [9:0] idx, input logic [31:0] v);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= v;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task wr(input logic [9:0] idx, input logic [31:0] v);
    apb(1'b1, idx, v);
  endtask

  task rd(input logic [9:0] idx);
    apb(1'b0, idx, 32'h0000_0000);
  endtask

  task wait_idle;
    do rd(`MSBT_IDX_STAT); while (q[0] !== 1'b0);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    wr(`MSBT_IDX_CFG, 32'h0000_0001);
    foreach (rows[i]) begin
      r = rows[i];
      lag <= {1'b0, r.sel};
      wr(`MSBT_IDX_CKCTL, {29'h0, r.sel});
      wr(`MSBT_IDX_DPTR0, {16'h0, r.addr});
      if (r.sel[0]) begin
        wr(`MSBT_IDX_XDATA, {24'h0, r.dat});
      end else begin
        xmem.mem[r.addr[7:0]] = r.dat;
      end
      base = cnt;
      wr(`MSBT_IDX_XCMD, {31'h0, r.sel[0]});
      t0 = cyc;
      wr(`MSBT_IDX_XCMD, {31'h0, r.sel[0]});
      wait_idle();
      e = cyc - t0;
      chk({31'h0, e >= r.tot && e <= r.tot + 5}, 32'h0000_0001);
      chk(d(0), 32'h0000_0004);
      chk(d(r.sel[0] ? 2 : 1), 32'(r.w));
      chk({16'h0, xaddr}, {16'h0, r.addr});
      if (r.sel[0]) begin
        chk({24'h0, xmem.mem[r.addr[7:0]]}, {24'h0, r.dat});
      end else begin
        chk({24'h0, q[15:8]}, {24'h0, r.dat});
      end
    end
    wr(`MSBT_IDX_CKCTL, 32'h0000_0001);
    base = cnt;
    repeat (48) @(posedge sys_clk);
    chk(d(3), 32'h0000_000c);
    chk(d(4), 32'h0000_0004);
    wr(`MSBT_IDX_CKCTL, 32'h0000_0009);
    base = cnt;
    repeat (48) @(posedge sys_clk);
    chk(d(4), 32'h0000_000c);
    wr(`MSBT_IDX_CFG, 32'h0000_00a5);
    base = cnt;
    repeat (16) @(posedge sys_clk);
    chk(d(3), 32'h0000_0000);
    chk({27'h0, core_idle, periph_pd}, 32'h0000_001a);
    wr(`MSBT_IDX_CFG, 32'h0000_0003);
    wr(`MSBT_IDX_DPTR1, 32'h0000_1230);
    wr(`MSBT_IDX_DPTR0, 32'h0000_4400);
    wr(`MSBT_IDX_XCMD, 32'h0000_0002);
    wait_idle();
    wr(`MSBT_IDX_XCMD, 32'h0000_0002);
    wait_idle();
    chk({16'h0, xaddr}, 32'h0000_1231);
    rd(`MSBT_IDX_DPTR1);
    chk(q, 32'h0000_1232);
    rd(`MSBT_IDX_DPTR0);
    chk(q, 32'h0000_4400);
    wr(`MSBT_IDX_SUMCTL, 32'h0000_0020);
    wr(`MSBT_IDX_SUM, 32'hffff_ffff);
    wr(`MSBT_IDX_SUM, 32'h0000_0012);
    rd(`MSBT_IDX_SUM);
    chk(q, 32'h0000_0011);
    wr(`MSBT_IDX_SUMCTL, 32'h0000_0004);
    rd(`MSBT_IDX_SUM);
    chk(q, 32'h0000_0001);
    wr(`MSBT_IDX_CFG, 32'h0000_0000);
    wr(`MSBT_IDX_GPIO, 32'hffc3_ffa5);
    base = cnt;
    wr(`MSBT_IDX_XCMD, 32'h0000_0000);
    repeat (12) @(posedge sys_clk);
    chk(d(0), 32'h0000_0000);
    chk({p2_oe, p2_out, p0_oe, p0_out}, 32'hffc3_ffa5);
    apb(1'b0, 10'h3ff, 32'h0000_0000);
    chk({31'h0, se}, 32'h0000_0001);
    chk(q, 32'h0000_0000);
    resetn <= 1'b0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    chk({13'h0, ale, rd_n, wr_n, p0_oe, p2_oe}, 32'h0003_0000);
    rd(`MSBT_IDX_CKCTL);
    chk(q, 32'h0000_0001);
    rd(`MSBT_IDX_CFG);
    chk(q, 32'h0000_0000);
    final_report();
  end
endmodule
